//--- rtl/cns_cmd_unit.sv
// command unit slice: no-operation and station-address setup execution
// Contract
// R1: opcode zero does only fetch and decode
// R2: next block address is base plus link
// R3: end-of-list goes idle after the block
// R4: end-of-list idle raises not-active/idle event
// R5: suspend flag suspends; event only if configured
// R6: interrupt flag raises command done event
// R7: issuer writes zeros to reserved bits
// R8: issuer clears completion; device sets it
// R9: success bit one means no error
// R10: no-operation writes completion and success as one
// R11: opcode one is station-address setup
// R12: engine holds 48-bit station address register
// R13: reset loads station address all ones
// R14: source inserted only when insertion not disabled
// R15: byte 1 at offset 08h, first on wire
// R16: start transmit dma at byte 1, count six
// R17: bytes pass fifo, completion may wait long
// R18: complete only after address update done
// R19: read four dwords at block start
// R20: no end or suspend fetches next block
// R21: setup success writes completion and success
`timescale 1ns/100ps
module cns_cmd_unit (
    input  wire logic                  i_core_clk,         // core clock, 40 MHz
    input  wire logic                  i_rst,              // synchronous reset
    input  wire logic                  i_start,            // start pulse at offset
    input  wire logic                  i_resume,           // resume pulse when suspended
    input  wire logic [31:0]           i_unit_base,        // command unit base
    input  wire logic [31:0]           i_start_offset,     // first block offset
    input  wire logic                  i_cfg_susp_event,   // suspend raises event
    input  wire logic                  i_cfg_no_src_insert,// source insert disable
    input  wire logic                  i_mem_rd_valid,     // one read dword valid
    input  wire logic [31:0]           i_mem_rd_data,      // read dword
    input  wire logic                  i_mem_wr_ack,       // status write taken
    input  wire logic                  i_txfifo_valid,     // address byte from fifo
    input  wire logic [7:0]            i_txfifo_byte,      // address byte
    output cns_pkg::cns_mem_req_t      o_mem,              // memory request
    output logic                       o_txdma_start,      // dma start pulse
    output logic [31:0]                o_txdma_addr,       // dma source address
    output logic [15:0]                o_txdma_count,      // dma byte count
    output logic [47:0]                o_station_address,  // node address
    output logic                       o_src_insert_en,    // insert source address
    output logic                       o_cmd_done_event,   // done event pulse
    output logic                       o_not_active_event, // not-active event pulse
    output cns_pkg::cns_unit_t         o_unit_state        // idle/active/suspended
);
    import cns_pkg::*;

    // ----------------------------------------------------------------
    // overview
    // ----------------------------------------------------------------
    // one block at a time: fetch four dwords, act, write status, post
    // events, then go idle, suspend or chain to the linked block.
    // memory requests are levels that stand until the last beat or ack.
    // no watchdog on the fifo wait: a stalled dma keeps the unit active,
    // since setup completion time has no upper bound.
    // reserved command bits are not checked, so a careless issuer
    // is not caught here; the trade is less decode logic.
    // the station register moves as one 48-bit word, so address match
    // never sees a half-loaded value.
    // unsupported opcodes still complete, with the success bit clear.

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cns_state_t   state,      next_state;      // sequencer
    cns_cmd_t     cmd,        next_cmd;        // fetched command word
    logic [31:0]  link,       next_link;       // fetched link field
    logic [31:0]  blk_addr,   next_blk_addr;   // current block address
    logic [2:0]   beat,       next_beat;       // read beat count
    logic [2:0]   nbyte,      next_nbyte;      // address bytes received
    logic [47:0]  shift,      next_shift;      // address assembly
    logic [47:0]  station,    next_station;    // station address register
    logic         err,        next_err;        // execution error seen
    cns_mem_req_t mem,        next_mem;        // memory lines
    logic         dma_go,     next_dma_go;     // dma start pulse
    logic         done_ev,    next_done_ev;    // done event pulse
    logic         na_ev,      next_na_ev;      // not-active pulse
    logic         ins_en,     next_ins_en;     // source insert enable
    logic [31:0]  dma_addr,   next_dma_addr;   // dma source address
    cns_unit_t    ustate,     next_ustate;     // unit condition

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_cmd      = cmd;
        next_link     = link;
        next_blk_addr = blk_addr;
        next_beat     = beat;
        next_nbyte    = nbyte;
        next_shift    = shift;
        next_station  = station;
        next_err      = err;
        next_mem      = mem;
        next_dma_go   = 1'b0;
        next_done_ev  = 1'b0;
        next_na_ev    = 1'b0;
        // R14: insertion follows config bit
        next_ins_en   = ~i_cfg_no_src_insert;
        next_ustate   = ustate;
        next_dma_addr = dma_addr;

        case (state)
            // waiting for a start command, or for a resume when suspended
            ST_IDLE, ST_SUSP: begin
                // start wins over resume when both come together
                if (i_start) begin
                    next_blk_addr = i_unit_base + i_start_offset;
                    next_state    = ST_FETCH;
                end else if (i_resume && state == ST_SUSP) begin
                    // R2: resume at linked block
                    next_blk_addr = i_unit_base + link;
                    next_state    = ST_FETCH;
                end
                if (next_state == ST_FETCH) begin
                    // R19: four-dword burst read
                    next_mem.rd   = 1'b1;
                    next_mem.addr = next_blk_addr;
                    next_beat     = 3'h0;
                    next_ustate   = UNIT_ACTIVE;
                end
            end

            // collect the four dwords in order
            ST_FETCH: begin
                // word 0 command, word 1 link; 2 and 3 unused here
                if (i_mem_rd_valid) begin
                    if (beat == 3'h0) begin
                        next_cmd = cns_cmd_t'(i_mem_rd_data);
                    end
                    if (beat == 3'h1) begin
                        next_link = i_mem_rd_data;
                    end
                    next_beat = beat + 3'h1;
                    if (beat == FETCH_WORDS - 3'h1) begin
                        next_mem.rd = 1'b0;
                        next_state  = ST_EXEC;
                    end
                end
            end

            // decode; reserved bits are not checked, issuer zeroes them
            ST_EXEC: begin
                next_err = 1'b0;
                if (cmd.op == OP_ADDR_SETUP) begin
                    // R11: setup command decode
                    // R16: dma from byte 1, six bytes
                    // R15: byte 1 lives at offset 08h
                    // address latched so it stands for the whole transfer
                    next_dma_addr = blk_addr + ADDR_OFS;
                    next_dma_go   = 1'b1;
                    next_nbyte    = 3'h0;
                    next_state  = ST_WAIT;
                end else begin
                    // R1: no-operation goes straight to status
                    // unsupported opcodes here finish with an error
                    next_err   = (cmd.op != OP_NOP);
                    next_state = ST_WRITE;
                end
                // raise the status strobe; the word is formed below
                if (next_state == ST_WRITE) begin
                    next_mem.wr = 1'b1;
                end
            end

            // R17: wait on fifo, no time bound
            ST_WAIT: begin
                // bytes are taken only here; strays elsewhere are dropped
                if (i_txfifo_valid) begin
                    // first wire byte ends up in the top bits
                    next_shift = {shift[39:0], i_txfifo_byte};
                    next_nbyte = nbyte + 3'h1;
                    if (nbyte == 3'(ADDR_BYTES - 16'h1)) begin
                        // R12: whole address updated at once
                        next_station = {shift[39:0], i_txfifo_byte};
                        // R18: completion only after update
                        next_mem.wr  = 1'b1;
                        next_state   = ST_WRITE;
                    end
                end
            end

            // status write back into the block header
            ST_WRITE: begin
                // request and word stand unchanged until the ack edge
                // an early ack is fine: the word went out with the strobe
                if (i_mem_wr_ack && mem.wr) begin
                    next_mem.wr = 1'b0;
                    next_state  = ST_POST;
                end
            end

            // events and choice of the next step
            ST_POST: begin
                // R6: done event only when asked
                next_done_ev = cmd.irq;
                if (cmd.eol) begin
                    // R3: end of list goes idle
                    // R4: idle always signalled
                    next_na_ev  = 1'b1;
                    next_ustate = UNIT_IDLE;
                    next_state  = ST_IDLE;
                end else if (cmd.susp) begin
                    // R5: suspend, event only if configured
                    next_na_ev  = i_cfg_susp_event;
                    next_ustate = UNIT_SUSP;
                    next_state  = ST_SUSP;
                end else begin
                    // R20: chain to the linked block
                    // rd rises with the events; no dead cycle between blocks
                    // R2: base plus link field
                    next_blk_addr = i_unit_base + link;
                    next_mem.rd   = 1'b1;
                    next_mem.addr = i_unit_base + link;
                    next_beat     = 3'h0;
                    next_state    = ST_FETCH;
                end
            end

            default: begin
                // unused state code: park in idle, drop the bus
                next_state  = ST_IDLE;
                next_ustate = UNIT_IDLE;
                next_mem    = '0;
            end
        endcase

        // status word set together with the strobe, so a partner that
        // acks in the first strobe cycle still stores the right word
        if (next_state == ST_WRITE && state != ST_WRITE) begin
            // R8: device sets completion bit
            // R10: no-operation completes with success
            // R21: setup completes with success
            // R9: success cleared on error
            next_mem.addr            = blk_addr;
            next_mem.wdata           = {cmd[31:16], 16'h0};
            next_mem.wdata[DONE_BIT] = 1'b1;
            next_mem.wdata[OK_BIT]   = ~next_err;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // plain registers; reset is synchronous and loads constants only
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state    <= ST_IDLE;
            cmd      <= '0;
            link     <= 32'h0;
            blk_addr <= 32'h0;
            beat     <= 3'h0;
            nbyte    <= 3'h0;
            shift    <= 48'h0;
            // R13: broadcast until first setup
            station  <= STATION_RST;
            err      <= 1'b0;
            mem      <= '0;
            dma_go   <= 1'b0;
            done_ev  <= 1'b0;
            na_ev    <= 1'b0;
            ins_en   <= 1'b0;
            // points at byte 1 of a block at zero
            dma_addr <= ADDR_OFS;
            ustate   <= UNIT_IDLE;
        end else begin
            state    <= next_state;
            cmd      <= next_cmd;
            link     <= next_link;
            blk_addr <= next_blk_addr;
            beat     <= next_beat;
            nbyte    <= next_nbyte;
            shift    <= next_shift;
            station  <= next_station;
            err      <= next_err;
            mem      <= next_mem;
            dma_go   <= next_dma_go;
            done_ev  <= next_done_ev;
            na_ev    <= next_na_ev;
            ins_en   <= next_ins_en;
            dma_addr <= next_dma_addr;
            ustate   <= next_ustate;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops except the constant dma byte count
    // ----------------------------------------------------------------
    assign o_mem              = mem;
    assign o_txdma_start      = dma_go;
    assign o_txdma_addr       = dma_addr;              // registered, holds during dma
    // byte count is a fixed constant, nothing to register
    assign o_txdma_count      = ADDR_BYTES;
    assign o_station_address  = station;
    assign o_src_insert_en    = ins_en;
    assign o_cmd_done_event   = done_ev;
    assign o_not_active_event = na_ev;
    assign o_unit_state       = ustate;

endmodule : cns_cmd_unit

//--- shared/cns_pkg.sv
// package: command word layout, opcodes, states and constants of the command unit
package cns_pkg;

    // ----------------------------------------------------------------
    // command block layout
    // ----------------------------------------------------------------
    localparam logic [2:0]  OP_NOP        = 3'h0;      // no-operation opcode
    localparam logic [2:0]  OP_ADDR_SETUP = 3'h1;      // station-address setup opcode
    localparam logic [31:0] ADDR_OFS      = 32'h8;     // first address byte offset
    localparam logic [2:0]  FETCH_WORDS   = 3'h4;      // dwords read per block
    localparam logic [15:0] ADDR_BYTES    = 16'h6;     // address bytes through dma
    localparam logic [47:0] STATION_RST   = 48'hffff_ffff_ffff; // broadcast
    localparam int          DONE_BIT      = 15;        // completion bit in status
    localparam int          OK_BIT        = 13;        // success bit in status

    // command word as it sits at offset 00h
    typedef struct packed {
        logic        eol;        // end of list
        logic        susp;       // suspend after
        logic        irq;        // interrupt on done
        logic [9:0]  rsvd;       // written zero by the issuer
        logic [2:0]  op;         // opcode
        logic [15:0] status;     // completion / success half
    } cns_cmd_t;

    // memory request lines
    typedef struct packed {
        logic        rd;         // read burst of four dwords
        logic        wr;         // single dword write
        logic [31:0] addr;       // byte address
        logic [31:0] wdata;      // write data
    } cns_mem_req_t;

    // unit condition seen by the rest of the controller
    typedef enum logic [1:0] {
        UNIT_IDLE   = 2'h0,
        UNIT_ACTIVE = 2'h1,
        UNIT_SUSP   = 2'h2
    } cns_unit_t;

    // sequencer states, gray along the setup path from idle through fetch, exec, wait and write to post
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_EXEC  = 3'h3,
        ST_WAIT  = 3'h2,
        ST_WRITE = 3'h6,
        ST_POST  = 3'h7,
        ST_SUSP  = 3'h5
    } cns_state_t;

endpackage : cns_pkg

//--- tb/cns_cmd_unit_checker.sv
// checker: port timing of the command unit
`timescale 1ns/100ps
module cns_cmd_unit_checker (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst,
    input wire logic                  i_cfg_susp_event,
    input wire logic                  i_cfg_no_src_insert,
    input wire logic                  i_mem_rd_valid,
    input wire logic [31:0]           i_mem_rd_data,
    input wire logic                  i_mem_wr_ack,
    input wire cns_pkg::cns_mem_req_t o_mem,
    input wire logic                  o_txdma_start,
    input wire logic [15:0]           o_txdma_count,
    input wire logic [47:0]           o_station_address,
    input wire logic                  o_src_insert_en,
    input wire logic                  o_cmd_done_event,
    input wire logic                  o_not_active_event,
    input wire cns_pkg::cns_unit_t    o_unit_state
);
    import cns_pkg::*;
    // ----------------------------------------------------------------
    // helper state, sampled only by the properties
    // ----------------------------------------------------------------
    logic [1:0] beat; // beats taken in this burst
    logic [2:0] op;   // opcode of the last fetch
    logic [2:0] fl;   // end, suspend, irq echoed in last status
    logic       tk;   // status write taken this cycle
    assign tk = o_mem.wr && i_mem_wr_ack;
    // beat count clears whenever the read is down
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_mem.rd) beat <= 2'h0;
        else if (i_mem_rd_valid) beat <= beat + 2'h1;
        if (o_mem.rd && i_mem_rd_valid && beat == 2'h0) op <= i_mem_rd_data[18:16];
        if (tk) fl <= o_mem.wdata[31:29];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_STATION_RST:
        assert property (disable iff (1'b0) i_rst |=> o_station_address == STATION_RST)
        else $error("station not all ones");
    AST_SRC_INSERT:
        assert property (1'b1 |=> o_src_insert_en == !$past(i_cfg_no_src_insert))
        else $error("source insert wrong");
    AST_STATION_HOLD:
        assert property (!$stable(o_station_address) |-> $rose(o_mem.wr))
        else $error("station moved early");
    AST_DMA_START:
        assert property (o_txdma_start |-> o_txdma_count == ADDR_BYTES && op == OP_ADDR_SETUP)
        else $error("bad dma start");
    AST_READ_FOUR:
        assert property (o_mem.rd && i_mem_rd_valid && beat == 2'h3 |=> !o_mem.rd)
        else $error("read not four beats");
    AST_STATUS:
        assert property (o_mem.wr |-> o_mem.wdata[DONE_BIT]
            && o_mem.wdata[OK_BIT] == (o_mem.wdata[18:17] == 2'h0))
        else $error("bad status word");
    AST_DONE_EVENT:
        assert property (tk |-> ##2 o_cmd_done_event == fl[0])
        else $error("done event wrong");
    AST_NEXT_STATE:
        assert property (tk |-> ##2 o_not_active_event == (fl[2] || (fl[1] && i_cfg_susp_event))
            && o_unit_state == (fl[2] ? UNIT_IDLE : fl[1] ? UNIT_SUSP : UNIT_ACTIVE)
            && o_mem.rd == !(fl[2] || fl[1]))
        else $error("wrong follow-up");
endmodule : cns_cmd_unit_checker

//--- tb/cns_cmd_unit_tb_top.sv
// testbench: chained no-operation, address setup, suspend and error blocks
`timescale 1ns/100ps
module cns_cmd_unit_tb_top;
    import cns_pkg::*;
    logic         i_core_clk = 1'b0;
    logic         i_rst, i_start, i_resume, i_cfg_susp_event, i_cfg_no_src_insert, slow;
    logic [31:0]  i_unit_base, i_start_offset, i_mem_rd_data, o_txdma_addr;
    logic         i_mem_rd_valid, i_mem_wr_ack, i_txfifo_valid, o_txdma_start;
    logic         o_src_insert_en, o_cmd_done_event, o_not_active_event;
    logic [7:0]   i_txfifo_byte;
    logic [15:0]  o_txdma_count;
    logic [47:0]  o_station_address;
    cns_mem_req_t o_mem;
    cns_unit_t    o_unit_state;
    int           bad_count = 0, samples_checked = 0, dn = 0, na = 0;
    initial forever #12.5 i_core_clk = ~i_core_clk;
    // event pulses counted as they land
    always @(posedge i_core_clk) begin
        if (o_cmd_done_event === 1'b1) dn++;
        if (o_not_active_event === 1'b1) na++;
    end
    cns_cmd_unit dut (.*);
    cns_host_mem host (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_slow(slow), .i_mem(o_mem),
        .i_dma_start(o_txdma_start), .i_dma_addr(o_txdma_addr), .i_dma_count(o_txdma_count),
        .o_rd_valid(i_mem_rd_valid), .o_rd_data(i_mem_rd_data), .o_wr_ack(i_mem_wr_ack),
        .o_tx_valid(i_txfifo_valid), .o_tx_byte(i_txfifo_byte));
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // issuer leaves reserved and status bits zero
    task automatic blk(input logic [7:0] a, input logic [31:0] c, l, w2, w3);
        {host.mem[a[7:2]], host.mem[a[7:2] + 6'h1]} = {c, l};
        {host.mem[a[7:2] + 6'h2], host.mem[a[7:2] + 6'h3]} = {w2, w3};
        {dn, na} = 0;
    endtask : blk
    // pulse start or resume, then wait for the unit to stop in st
    task automatic run_to(input logic res, input cns_unit_t st);
        int k;
        {i_start, i_resume} = {!res, res};
        @(negedge i_core_clk);
        {i_start, i_resume} = 2'h0;
        @(negedge i_core_clk);
        for (k = 0; k < 400 && o_unit_state !== st; k++) @(negedge i_core_clk);
        // event pulses land with the state and are counted one edge later
        @(negedge i_core_clk);
        if (k == 400) begin
            bad_count++;
            $display("Error state expected %0d seen %0d", st, o_unit_state);
            finish_test();
        end
    endtask : run_to
    task automatic t_reset();
        chk("station", STATION_RST, o_station_address);
        chk("insert", 48'h1, 48'(o_src_insert_en));
        i_cfg_no_src_insert = 1'b1;
        @(negedge i_core_clk);
        chk("insert", 48'h0, 48'(o_src_insert_en));
        i_cfg_no_src_insert = 1'b0;
    endtask : t_reset
    task automatic t_chain();
        blk(8'h40, 32'h2000_0000, 32'h20, 32'h0, 32'h0);
        blk(8'h60, 32'h8001_0000, 32'h0, 32'h0100_aa00, 32'hdead_0302);
        run_to(1'b0, UNIT_IDLE);
        chk("nop status", 48'h2000_a000, 48'(host.mem[16]));
        chk("setup status", 48'h8001_a000, 48'(host.mem[24]));
        chk("station", 48'h00aa_0001_0203, o_station_address);
        chk("done events", 48'h1, 48'(dn));
        chk("idle events", 48'h1, 48'(na));
    endtask : t_chain
    task automatic t_suspend();
        slow = 1'b1;
        i_start_offset = 32'h80;
        blk(8'hc0, 32'h6001_0000, 32'h90, 32'h4433_2211, 32'h0000_6655);
        blk(8'hd0, 32'h8002_0000, 32'h0, 32'h0, 32'h0);
        run_to(1'b0, UNIT_SUSP);
        chk("station", 48'h1122_3344_5566, o_station_address);
        chk("setup status", 48'h6001_a000, 48'(host.mem[48]));
        chk("events", 48'h1_0000_0000, {16'(dn), 32'(na)});
        i_cfg_susp_event = 1'b1;
        run_to(1'b1, UNIT_IDLE);
        chk("error status", 48'h8002_8000, 48'(host.mem[52]));
        chk("station", 48'h1122_3344_5566, o_station_address);
        chk("events", 48'h1_0000_0001, {16'(dn), 32'(na)});
    endtask : t_suspend
    task automatic t_nop_susp();
        slow = 1'b0;
        i_start_offset = 32'h30;
        blk(8'h70, 32'h4000_0000, 32'h0, 32'h0, 32'h0);
        run_to(1'b0, UNIT_SUSP);
        chk("nop status", 48'h4000_a000, 48'(host.mem[28]));
        chk("events", 48'h0_0000_0001, {16'(dn), 32'(na)});
    endtask : t_nop_susp
    initial begin
        {i_rst, i_start, i_resume, i_cfg_susp_event, i_cfg_no_src_insert, slow} = 6'h20;
        {i_unit_base, i_start_offset} = {32'h40, 32'h0};
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        repeat (2) @(negedge i_core_clk);
        t_reset();
        t_chain();
        t_suspend();
        t_nop_susp();
        finish_test();
    end
endmodule : cns_cmd_unit_tb_top
bind cns_cmd_unit cns_cmd_unit_checker chk_u (.*);

//--- tb/cns_host_mem.sv
// host memory model: command blocks, status writes and dma bytes
`timescale 1ns/100ps
module cns_host_mem (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_slow,      // answer every other cycle
    input  wire cns_pkg::cns_mem_req_t i_mem,
    input  wire logic                  i_dma_start,
    input  wire logic [31:0]           i_dma_addr,
    input  wire logic [15:0]           i_dma_count,
    output logic                       o_rd_valid,
    output logic [31:0]                o_rd_data,
    output logic                       o_wr_ack,
    output logic                       o_tx_valid,
    output logic [7:0]                 o_tx_byte
);
    import cns_pkg::*;
    logic [31:0] mem [0:63]; // 256 bytes of host memory
    logic [2:0]  beat;       // dwords handed out this burst
    logic [15:0] left;       // dma bytes still owed
    logic [31:0] ptr;        // dma byte pointer
    logic        seen;       // write data settled
    logic        tick = 1'b0;
    initial {o_rd_valid, o_wr_ack, o_tx_valid, o_rd_data, o_tx_byte} = '0;
    // one process; released lines show changing junk, not a stale value
    always @(posedge i_core_clk) begin
        tick <= ~tick;
        {o_rd_valid, o_wr_ack, o_tx_valid} <= 3'h0;
        o_rd_data <= ~o_rd_data;
        o_tx_byte <= ~o_tx_byte;
        seen <= i_mem.wr && !o_wr_ack;
        if (i_rst || !i_mem.rd) beat <= 3'h0;
        else if (beat < 3'h4 && (tick || !i_slow)) begin
            o_rd_valid <= 1'b1;
            o_rd_data <= mem[i_mem.addr[7:2] + 6'(beat)];
            beat <= beat + 3'h1;
        end
        // status taken once its data has settled
        if (i_mem.wr && seen && !o_wr_ack && (tick || !i_slow)) begin
            o_wr_ack <= 1'b1;
            mem[i_mem.addr[7:2]] <= i_mem.wdata;
        end
        if (i_rst) left <= 16'h0;
        else if (i_dma_start) begin
            ptr <= i_dma_addr;
            left <= i_dma_count;
        end
        // byte 1 sits in the lowest lane
        else if (left != 16'h0 && (tick || !i_slow)) begin
            o_tx_valid <= 1'b1;
            o_tx_byte <= mem[ptr[7:2]][8 * ptr[1:0] +: 8];
            ptr <= ptr + 32'h1;
            left <= left - 16'h1;
        end
    end
endmodule : cns_host_mem
